// >>> design/dsfs_defines.svh
// constants for the device state and fault sequencer
`ifndef DSFS_DEFINES_SVH
`define DSFS_DEFINES_SVH
`define DSFS_COLD_CYCLES     16'h0040
`define DSFS_WARM_CYCLES     16'h0020
`define DSFS_NMI_TIMEOUT     16'h0100
`define DSFS_PIN_PULSE       16'h0010
`define DSFS_GRP_BITS        3
`endif

// >>> design/dsfs_pkg.sv
// types for the device state and fault sequencer
package dsfs_pkg;
  // one-hot operating states
  typedef enum logic [7:0] {
    DSFS_OFF    = 8'h01,
    DSFS_RESET  = 8'h02,
    DSFS_COLD   = 8'h04,
    DSFS_WARM   = 8'h08,
    DSFS_PREOP  = 8'h10,
    DSFS_OPER   = 8'h20,
    DSFS_SAFE   = 8'h40
  } dsfs_state_t;
endpackage : dsfs_pkg

// >>> design/dsfs_sequencer.sv
// operating-state sequencer with graded fault response
`timescale 1ns/1ps
`include "dsfs_defines.svh"
module dsfs_sequencer #(
  parameter int NSRC  = 16,                 // peripheral interrupt sources
  parameter int NGRP  = 4,                  // processor interrupt lines
  parameter logic [15:0] COLD_CYCLES = `DSFS_COLD_CYCLES,
  parameter logic [15:0] WARM_CYCLES = `DSFS_WARM_CYCLES,
  parameter logic [15:0] NMI_TIMEOUT = `DSFS_NMI_TIMEOUT,
  parameter logic [15:0] PIN_PULSE   = `DSFS_PIN_PULSE
) (
  input  wire logic               clk_sys,
  input  wire logic               rstn,
  input  wire logic               power_good,        // supply present
  input  wire logic               warm_reset_pin_n_i,// pin level in
  input  wire logic               fault_powerdown,   // supervisor fault
  input  wire logic               fault_pin_reset,   // critical fault
  input  wire logic               security_violation,// monitor event
  input  wire logic               fault_nmi,         // nmi-class fault
  input  wire logic [NSRC-1:0]    periph_irq,        // irq sources
  input  wire logic               boot_done,         // boot rom finished
  input  wire logic               app_ready,         // self-tests passed
  input  wire logic               nmi_ack,           // nmi serviced
  input  wire logic               safe_req,          // enter safe state
  output logic                    warm_reset_pin_n_o,// pin drive value
  output logic                    warm_reset_pin_n_oe,// pin drive enable
  output logic                    error_status_pin,  // fault to outside
  output logic                    powerdown_req,     // ask supply cut
  output logic                    cpu_reset_n,       // processor reset
  output logic                    cpu_fetch_rom,     // fetch from boot rom
  output logic                    cpu_nmi,           // nmi to processor
  output logic [NGRP-1:0]         cpu_irq,           // expanded irq lines
  output logic                    safety_capable,    // operational only
  output logic                    outputs_inactive,  // actuators off
  output dsfs_pkg::dsfs_state_t   op_state           // encoded state
);
  import dsfs_pkg::*;

  localparam int PER = NSRC / NGRP;          // sources per line

  // pin synchroniser, three stages
  logic [2:0]  pin_sync_r;
  logic        pin_low_r;                    // filtered pin level low
  logic        pg_sync1_r, pg_sync2_r, pg_sync3_r;
  logic        pg_r;                         // filtered power good

  dsfs_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;               // boot phase counter
  logic [15:0] nmi_cnt_r;                    // nmi service timer
  logic [15:0] pin_cnt_r;                    // pin pulse timer
  logic        nmi_pend_r;                   // nmi awaiting ack

  // three-stage sync, change accepted once stages 2 and 3 agree
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_sync_r <= 3'h7;
      pin_low_r  <= 1'b0;
      pg_sync1_r <= 1'b0;
      pg_sync2_r <= 1'b0;
      pg_sync3_r <= 1'b0;
      pg_r       <= 1'b0;
    end
    else
    begin
      pin_sync_r <= {pin_sync_r[1:0], warm_reset_pin_n_i};
      if (pin_sync_r[1] == pin_sync_r[2])
        pin_low_r <= ~pin_sync_r[2];
      pg_sync1_r <= power_good;
      pg_sync2_r <= pg_sync1_r;
      pg_sync3_r <= pg_sync2_r;
      if (pg_sync2_r == pg_sync3_r)
        pg_r <= pg_sync3_r;
    end
  end

  // nmi left unserviced too long escalates to the pin
  wire nmi_expired = nmi_pend_r && (nmi_cnt_r == NMI_TIMEOUT);

  // severity ladder: one-hot grant of the top request
  wire req_pd  = fault_powerdown;
  wire req_pin = fault_pin_reset | nmi_expired;
  wire req_cpu = security_violation;
  wire req_nmi = fault_nmi;
  wire act_pd  = req_pd;
  wire act_pin = req_pin & ~req_pd;
  wire act_cpu = req_cpu & ~req_pin & ~req_pd;
  wire act_nmi = req_nmi & ~req_cpu & ~req_pin & ~req_pd;
  wire act_irq = ~req_nmi & ~req_cpu & ~req_pin & ~req_pd;

  // processor is running code in these states
  wire cpu_running = (state_r == DSFS_WARM) || (state_r == DSFS_PREOP)
                   || (state_r == DSFS_OPER);
  wire cpu_app     = (state_r == DSFS_PREOP) || (state_r == DSFS_OPER);
  wire pin_drv     = (pin_cnt_r != 16'h0000);
  wire any_reset   = pin_low_r | pin_drv;

  // next state
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + 16'h0001;
    if (!pg_r)
    begin
      state_nxt = DSFS_OFF;
      cnt_nxt   = 16'h0000;
    end
    else if (act_pd && state_r != DSFS_OFF)
    begin
      state_nxt = DSFS_OFF;
      cnt_nxt   = 16'h0000;
    end
    else if (any_reset || act_pin)
    begin
      state_nxt = DSFS_RESET;
      cnt_nxt   = 16'h0000;
    end
    else if (act_cpu && cpu_app)
    begin
      state_nxt = DSFS_WARM;
      cnt_nxt   = 16'h0000;
    end
    else
    begin
      case (state_r)
        DSFS_OFF:
        begin
          state_nxt = DSFS_COLD;
          cnt_nxt   = 16'h0000;
        end
        DSFS_RESET:
        begin
          state_nxt = DSFS_COLD;
          cnt_nxt   = 16'h0000;
        end
        DSFS_COLD:
        begin
          if (cnt_r >= COLD_CYCLES - 16'h0001)
          begin
            state_nxt = DSFS_WARM;
            cnt_nxt   = 16'h0000;
          end
        end
        DSFS_WARM:
        begin
          if (boot_done && cnt_r >= WARM_CYCLES - 16'h0001)
          begin
            state_nxt = DSFS_PREOP;
            cnt_nxt   = 16'h0000;
          end
        end
        DSFS_PREOP:
        begin
          if (app_ready)
            state_nxt = DSFS_OPER;
          cnt_nxt = 16'h0000;
        end
        DSFS_OPER:
        begin
          if (safe_req)
            state_nxt = DSFS_SAFE;
          cnt_nxt = 16'h0000;
        end
        DSFS_SAFE:
        begin
          cnt_nxt = 16'h0000;
        end
        default:
        begin
          state_nxt = DSFS_OFF;
          cnt_nxt   = 16'h0000;
        end
      endcase
    end
    if (cnt_r == 16'hffff && cnt_nxt == 16'h0000 && state_nxt == state_r)
      cnt_nxt = cnt_r;
  end

  // state register, moves on the rising edge, reset to DSFS_OFF is asynchronous
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= DSFS_OFF;
      cnt_r   <= 16'h0000;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // nmi pending flag and its service timer; new nmi wins over ack
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      nmi_pend_r <= 1'b0;
      nmi_cnt_r  <= 16'h0000;
    end
    else if (!cpu_running)
    begin
      nmi_pend_r <= 1'b0;
      nmi_cnt_r  <= 16'h0000;
    end
    else if (act_nmi)
    begin
      nmi_pend_r <= 1'b1;
      if (!nmi_pend_r)
        nmi_cnt_r <= 16'h0000;
    end
    else if (nmi_ack)
    begin
      nmi_pend_r <= 1'b0;
      nmi_cnt_r  <= 16'h0000;
    end
    else if (nmi_pend_r && !nmi_expired)
      nmi_cnt_r <= nmi_cnt_r + 16'h0001;
  end

  // warm reset pin pulse timer
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      pin_cnt_r <= 16'h0000;
    else if (act_pin && pg_r)
      pin_cnt_r <= PIN_PULSE;
    else if (pin_drv)
      pin_cnt_r <= pin_cnt_r - 16'h0001;
  end

  // interrupt expansion: or of each source group per line
  logic [NGRP-1:0] grp_or;
  genvar g;
  generate
    for (g = 0; g < NGRP; g++)
    begin : g_grp
      assign grp_or[g] = |periph_irq[g*PER +: PER];
    end
  endgenerate

  // registered outputs
  wire err_nxt = (act_nmi & cpu_running) | (nmi_pend_r & cpu_running)
               | (state_nxt == DSFS_SAFE);
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      warm_reset_pin_n_o  <= 1'b1;
      warm_reset_pin_n_oe <= 1'b0;
      error_status_pin    <= 1'b0;
      powerdown_req       <= 1'b0;
      cpu_reset_n         <= 1'b0;
      cpu_fetch_rom       <= 1'b0;
      cpu_nmi             <= 1'b0;
      cpu_irq             <= '0;
      safety_capable      <= 1'b0;
      outputs_inactive    <= 1'b1;
      op_state            <= DSFS_OFF;
    end
    else
    begin
      warm_reset_pin_n_o  <= 1'b0;
      warm_reset_pin_n_oe <= (act_pin & pg_r) | (pin_cnt_r > 16'h0001);
      error_status_pin    <= err_nxt;
      powerdown_req       <= act_pd;
      cpu_reset_n         <= (state_nxt == DSFS_WARM)
                           || (state_nxt == DSFS_PREOP)
                           || (state_nxt == DSFS_OPER);
      cpu_fetch_rom       <= (state_nxt == DSFS_WARM);
      cpu_nmi             <= cpu_running & (act_nmi | nmi_pend_r)
                           & ~nmi_ack;
      cpu_irq             <= (cpu_running & act_irq) ? grp_or : '0;
      safety_capable      <= (state_nxt == DSFS_OPER);
      outputs_inactive    <= (state_nxt != DSFS_OPER)
                           && (state_nxt != DSFS_PREOP);
      op_state            <= state_nxt;
    end
  end

endmodule : dsfs_sequencer

// >>> verification/dsfs_asserts.sv
// concurrent checks on the device state and fault sequencer ports
`timescale 1ns/1ps
module dsfs_asserts
  import dsfs_pkg::*;
#(
  parameter int NGRP = 4  // processor interrupt lines
) (
  input wire logic                  clk_sys,
  input wire logic                  rstn,
  input wire logic                  fault_powerdown,
  input wire logic                  fault_pin_reset,
  input wire logic                  security_violation,
  input wire logic                  fault_nmi,
  input wire logic                  warm_reset_pin_n_oe,
  input wire logic                  error_status_pin,
  input wire logic                  cpu_reset_n,
  input wire logic                  cpu_fetch_rom,
  input wire logic                  cpu_nmi,
  input wire logic [NGRP-1:0]       cpu_irq,
  input wire logic                  safety_capable,
  input wire dsfs_pkg::dsfs_state_t op_state
);
  // one clock domain, one reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  a_state_onehot: assert property ($onehot(op_state))
    else $error("state code not one-hot");
  a_cpu_held_cold: assert property (op_state == DSFS_COLD |-> !cpu_reset_n)
    else $error("processor out of reset in cold boot");
  a_rom_fetch_warm: assert property (cpu_fetch_rom == (op_state == DSFS_WARM))
    else $error("rom fetch not tied to warm boot");
  a_safety_oper: assert property (safety_capable == (op_state == DSFS_OPER))
    else $error("safety flag outside operational");
  a_nmi_cause: assert property ($rose(cpu_nmi) |-> $past(fault_nmi))
    else $error("nmi raised without a fault");
  a_nmi_err_pin: assert property (cpu_nmi |-> error_status_pin)
    else $error("nmi without error status pin");
  a_irq_yields: assert property (fault_nmi |=> cpu_irq == '0)
    else $error("interrupt lines active beside a fault");
  a_pin_reset: assert property ($rose(warm_reset_pin_n_oe) |-> op_state == DSFS_RESET)
    else $error("pin drive outside reset state");
  a_reset_exit: assert property ($fell(op_state == DSFS_RESET) |-> op_state inside {DSFS_COLD, DSFS_OFF})
    else $error("reset left to a state other than cold boot");
  a_cold_entry: assert property (op_state == DSFS_OFF ##1 op_state != DSFS_OFF |-> op_state == DSFS_COLD)
    else $error("power-up not through cold boot");
  a_sec_warm: assert property (security_violation && !fault_powerdown && !fault_pin_reset && op_state == DSFS_OPER |=> op_state == DSFS_WARM)
    else $error("security event did not restart warm boot");
  a_pd_off: assert property (fault_powerdown |=> op_state == DSFS_OFF)
    else $error("power-down fault did not reach off");
  // main scenarios reached
  c_oper: cover property (op_state == DSFS_OPER);
  c_nmi: cover property ($rose(cpu_nmi));
  c_pin: cover property ($rose(warm_reset_pin_n_oe));
  c_safe: cover property (op_state == DSFS_SAFE);
endmodule : dsfs_asserts

bind dsfs_sequencer dsfs_asserts #(.NGRP(NGRP)) u_chk (.*);

// >>> verification/dsfs_supervisor.sv
// external supervisor: pulled-up reset pin and switchable supply
`timescale 1ns/1ps
module dsfs_supervisor #(
  parameter int OFF_CYC = 8  // supply stays cut for OFF_CYC plus one cycles
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic warm_reset_pin_n_o,
  input  wire logic warm_reset_pin_n_oe,
  input  wire logic powerdown_req,
  input  wire logic ext_rst_n,
  output wire logic warm_reset_pin_n_i,
  output logic      power_good
);
  int   off_cnt;  // remaining cut cycles
  logic req_d;    // request seen last cycle
  // pin is pulled up, low while either party pulls it down
  assign warm_reset_pin_n_i = ext_rst_n &
    !(warm_reset_pin_n_oe & !warm_reset_pin_n_o);
  // cut the supply on a fresh request, restore after OFF_CYC plus one cycles
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      off_cnt    <= 0;
      req_d      <= 1'b0;
      power_good <= 1'b1;
    end
    else
    begin
      req_d <= powerdown_req;
      if (powerdown_req && !req_d)  // supervisor removes power
        off_cnt <= OFF_CYC;
      else if (off_cnt > 0)
        off_cnt <= off_cnt - 1;
      power_good <= (off_cnt == 0) && !(powerdown_req && !req_d);
    end
  end
endmodule : dsfs_supervisor

// >>> verification/dsfs_sequencer_tb.sv
// self-checking bench for the device state and fault sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_fail++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module dsfs_sequencer_tb;
  import dsfs_pkg::*;
  logic clk_sys = 0, rstn = 0, fault_powerdown = 0, fault_pin_reset = 0;
  logic security_violation = 0, fault_nmi = 0, boot_done = 0;
  logic app_ready = 0, nmi_ack = 0, safe_req = 0, ext_rst_n = 1;
  logic [15:0] periph_irq = '0;       // interrupt sources
  logic [3:0]  cpu_irq;               // expanded lines
  wire logic   power_good, warm_reset_pin_n_i;
  logic warm_reset_pin_n_o, warm_reset_pin_n_oe, error_status_pin;
  logic powerdown_req, cpu_reset_n, cpu_fetch_rom, cpu_nmi;
  logic safety_capable, outputs_inactive;
  dsfs_state_t op_state;              // observed state
  int n_fail = 0, tests_run = 0, cyc = 0;
  // short counts so the whole run stays brief
  dsfs_sequencer #(.NSRC(16), .NGRP(4), .COLD_CYCLES(16'h0004),
    .WARM_CYCLES(16'h0004), .NMI_TIMEOUT(16'h0008),
    .PIN_PULSE(16'h0004)) i_dut (.*);
  dsfs_supervisor #(.OFF_CYC(8)) i_sup (.*);
  // 200 MHz clock
  always #2.5 clk_sys = ~clk_sys;
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  // wait a bounded time for a state, then compare
  task automatic wait_state(input dsfs_state_t s, input int lim);
    int k;
    k = 0;
    while (op_state !== s && k < lim)
    begin
      @(negedge clk_sys);
      k++;
    end
    `CHK("op_state", s, op_state)
  endtask : wait_state
  // one-cycle high pulse launched at a falling edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask : pulse
  // full boot from cold to operational
  task t_boot;
    wait_state(DSFS_COLD, 24);
    `CHK("cpu_reset_n", 1'b0, cpu_reset_n)
    wait_state(DSFS_WARM, 12);
    `CHK("cpu_fetch_rom", 1'b1, cpu_fetch_rom)
    // boot rom not yet done: warm boot must hold
    boot_done = 1'b0;
    app_ready = 1'b0;
    repeat (6) @(negedge clk_sys);
    `CHK("op_state", DSFS_WARM, op_state)
    boot_done = 1'b1;
    wait_state(DSFS_PREOP, 12);
    `CHK("safety_capable", 1'b0, safety_capable)
    // self-tests pending: pre-operational must hold
    repeat (3) @(negedge clk_sys);
    `CHK("op_state", DSFS_PREOP, op_state)
    app_ready = 1'b1;
    wait_state(DSFS_OPER, 12);
    `CHK("safety_capable", 1'b1, safety_capable)
  endtask : t_boot
  // interrupt expansion, then nmi outranking it, then service
  task t_irq_nmi;
    periph_irq = 16'h0020;
    repeat (2) @(negedge clk_sys);
    `CHK("cpu_irq", 4'h2, cpu_irq)
    pulse(fault_nmi);
    `CHK("cpu_nmi", 1'b1, cpu_nmi)
    `CHK("error_status_pin", 1'b1, error_status_pin)
    `CHK("cpu_irq", 4'h0, cpu_irq)
    pulse(nmi_ack);
    `CHK("cpu_nmi", 1'b0, cpu_nmi)
    periph_irq = '0;
  endtask : t_irq_nmi
  // unserviced nmi escalates to a pin reset and a cold restart
  task t_nmi_timeout;
    pulse(fault_nmi);
    wait_state(DSFS_RESET, 16);
    `CHK("pin_oe", 1'b1, warm_reset_pin_n_oe)
    `CHK("cpu_reset_n", 1'b0, cpu_reset_n)
    t_boot();
  endtask : t_nmi_timeout
  // security event restarts warm boot only
  task t_cpu_reset;
    pulse(security_violation);
    `CHK("op_state", DSFS_WARM, op_state)
    wait_state(DSFS_OPER, 24);
  endtask : t_cpu_reset
  // outside party pulls the reset pin
  task t_pin_reset;
    ext_rst_n = 1'b0;
    wait_state(DSFS_RESET, 8);
    ext_rst_n = 1'b1;
    t_boot();
  endtask : t_pin_reset
  // second reset in mid-run, then a fresh boot
  task t_mid_reset;
    rstn = 1'b0;
    @(negedge clk_sys);
    `CHK("op_state", DSFS_OFF, op_state)
    `CHK("cpu_reset_n", 1'b0, cpu_reset_n)
    rstn = 1'b1;
    t_boot();
  endtask : t_mid_reset
  // safe state, then power-down beside a pin request
  task t_safe_pd;
    pulse(safe_req);
    `CHK("op_state", DSFS_SAFE, op_state)
    `CHK("outputs_inactive", 1'b1, outputs_inactive)
    `CHK("error_status_pin", 1'b1, error_status_pin)
    fault_pin_reset = 1'b1;
    pulse(fault_powerdown);
    fault_pin_reset = 1'b0;
    `CHK("op_state", DSFS_OFF, op_state)
    `CHK("powerdown_req", 1'b1, powerdown_req)
    `CHK("pin_oe", 1'b0, warm_reset_pin_n_oe)
    // supervisor cuts the supply, then restores it
    @(negedge power_good);
    @(posedge power_good);
    @(negedge clk_sys);
    `CHK("op_state", DSFS_OFF, op_state)
    t_boot();
  endtask : t_safe_pd
  // main sequence
  initial
  begin
    repeat (10) @(negedge clk_sys);
    `CHK("op_state", DSFS_OFF, op_state)
    rstn = 1'b1;
    boot_done = 1'b1;
    app_ready = 1'b1;
    t_boot();
    t_irq_nmi();
    t_nmi_timeout();
    t_cpu_reset();
    t_pin_reset();
    t_mid_reset();
    t_safe_pd();
    report_and_stop();
  end
endmodule : dsfs_sequencer_tb
